/* File: hdl/aurm_cfg.svh */
// Register map, reset values, field positions and timing for the bank
// Function
// [RL1] 64 consecutive ones reset all registers
// [RL2] Host includes software reset at initialization
// [RL3] Host waits power-on delay before access
// [RL4] Early transaction ignored, sets early-access error; the bank drops early writes but still answers early reads
// [RL5] Early-access error clears only on write-one
// [RL6] Host configures interface, setups, channels, mode
// [RL7] Writes never alter read-only bits
// [RL8] Sixteen channel registers from 0x09, reset values
// [RL9] Eight setup registers 0x19-0x20, reset zero
// [RL10] Eight filter registers 0x21-0x28, reset 0x002030
// [RL11] Eight offset registers 0x29-0x30, reset mid-scale
// [RL12] Gain registers load factory trim on reset
// [RL13] Most significant byte first, register-sized reads
// [RL14] Unmapped writes ignored, unmapped reads zero
`ifndef AURM_CFG_SVH
`define AURM_CFG_SVH

// Register offsets
`define AURM_ADDR_STATUS   6'h00
`define AURM_ADDR_CTL      6'h01
`define AURM_ADDR_RESULT   6'h02
`define AURM_ADDR_IO       6'h03
`define AURM_ADDR_VBIAS    6'h04
`define AURM_ADDR_PARTID   6'h05
`define AURM_ADDR_FAULT    6'h06
`define AURM_ADDR_FAULTEN  6'h07
`define AURM_ADDR_TALLY    6'h08
`define AURM_CHAN_BASE     6'h09
`define AURM_CHAN_LAST     6'h18
`define AURM_CFG_BASE      6'h19
`define AURM_CFG_LAST      6'h20
`define AURM_FILT_BASE     6'h21
`define AURM_FILT_LAST     6'h28
`define AURM_OFFS_BASE     6'h29
`define AURM_OFFS_LAST     6'h30
`define AURM_GAIN_BASE     6'h31
`define AURM_GAIN_LAST     6'h38
`define AURM_ADDR_MISC     6'h39
`define AURM_ADDR_QCTL     6'h3a
`define AURM_ADDR_QSTATE   6'h3b
`define AURM_ADDR_QLIM     6'h3c
`define AURM_ADDR_QDATA    6'h3d
`define AURM_ADDR_LAST     6'h3d

// Reset values
`define AURM_RST_STATUS    8'h10
`define AURM_RST_CTL       16'h4000
`define AURM_RST_IO        16'h0000
`define AURM_RST_VBIAS     16'h0000
`define AURM_RST_FAULTEN   16'h0040
`define AURM_RST_CHAN0     24'h800100
`define AURM_RST_CHAN      24'h000100
`define AURM_RST_CFG       16'h0000
`define AURM_RST_FILT      24'h002030
`define AURM_RST_OFFS      24'h800000
`define AURM_GAIN_NOMINAL  28'h5555555
`define AURM_RST_MISC      16'h0000
`define AURM_RST_QCTL      24'h040200
`define AURM_RST_QSTATE    8'h01
`define AURM_RST_QLIM      24'hfff000

// Writable-bit masks of the mixed registers
`define AURM_MASK_CTL      16'h7f7f
`define AURM_MASK_IO       16'h07ee
`define AURM_MASK_VBIAS    16'hcc33
`define AURM_MASK_FAULTEN  16'h1fff

// Field positions
`define AURM_CMD_WEN_BIT   7
`define AURM_CMD_RD_BIT    6
`define AURM_FAULT_IGN_BIT 6
`define AURM_EN_TALLY_BIT  12

// Timing
`define AURM_SWRST_ONES     64
`define AURM_MCLK_PERIOD_NS 10
`define AURM_RESET_DELAY_NS 2000
`define AURM_RESET_DELAY_CYC ((`AURM_RESET_DELAY_NS + `AURM_MCLK_PERIOD_NS - 1) / `AURM_MCLK_PERIOD_NS)

`endif

/* File: hdl/aurm_pkg.sv */
// Types shared by the register bank
package aurm_pkg;
  // Link-side transaction phase
  typedef enum logic [1:0] {ls_cmd, ls_wr, ls_rd, ls_skip} aurm_lstate_t;
endpackage

/* File: hdl/aurm_regbank.sv */
// Register bank with serial slave on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "aurm_cfg.svh"
module aurm_regbank #(
  parameter int         DLY_CYC = `AURM_RESET_DELAY_CYC, // Init delay
  parameter logic [7:0] PART_ID = 8'h3c // Arbitrary identity value
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output var  logic        sdo,
  output logic             sdo_oe,
  input  wire logic [23:0] gain_trim,
  output var  logic        dev_ready,
  output var  logic [15:0] conv_ctl
);
  localparam int DW = $clog2(DLY_CYC + 1);

  // Link-side state
  aurm_pkg::aurm_lstate_t phase_r;   // Transaction phase
  logic [2:0]  bit_cnt_r;            // Bit within byte
  logic [1:0]  byte_cnt_r;           // Data byte index
  logic [7:0]  sh_r;                 // Input shift register
  logic [7:0]  sh_nxt;               // Shift register with new bit
  logic [5:0]  addr_r;               // Addressed register
  logic [5:0]  ones_r;               // Run of ones
  logic [23:0] acc_r;                // Write data gathered
  logic [23:0] rd_sh_r;              // Read data, MSB at top
  logic [1:0]  cur_len;              // Bytes of addressed register
  logic [1:0]  rd_len;               // Bytes of register being read
  logic [23:0] rd_word;              // Register value, right aligned
  logic [5:0]  rd_addr;              // Address in arriving command
  logic        byte_end;             // Last bit of a byte
  logic        sw_hit;               // Reset run complete
  logic        wr_tgl_r;             // Commit event toggle
  logic        rst_tgl_r;            // Software reset toggle
  logic [5:0]  wa_r;                 // Committed address
  logic [23:0] wd_r;                 // Committed data

  // Master-side state
  logic          cs_lvl;             // Synchronised select
  logic          cs_chg;             // Select changed
  logic          wr_p;               // Commit arrived
  logic          swr_p;              // Software reset arrived
  logic          init;               // Any reset
  logic          wr_ok;              // Commit accepted
  logic          frame_start;        // Frame opened
  logic [DW-1:0] dly_r;              // Init delay counter
  logic          ready_r;            // Initialisation done
  logic          bad_r;              // Current frame came early
  logic          ign_r;              // Early-access error flag
  logic [7:0]    tally_r;            // Master clock tally
  logic [15:0]   ctl_r, io_r, vbias_r, faulten_r, misc_r;
  logic [23:0]   qctl_r, qlim_r;
  logic [23:0]   chan_r [16];        // Channel slots
  logic [15:0]   cfg_r  [8];         // Setup words
  logic [23:0]   filt_r [8];         // Filter words
  logic [23:0]   offs_r [8];         // Offset trims
  logic [23:0]   gain_r [8];         // Gain trims

  // Register byte count by address
  function automatic logic [1:0] reg_len(input logic [5:0] a);
    logic [1:0] n;
    n = 2'd1;
    if (a == `AURM_ADDR_CTL || a == `AURM_ADDR_IO ||
        a == `AURM_ADDR_VBIAS || a == `AURM_ADDR_FAULT ||
        a == `AURM_ADDR_FAULTEN || a == `AURM_ADDR_MISC ||
        (a >= `AURM_CFG_BASE && a <= `AURM_CFG_LAST))
      n = 2'd2;
    else if (a == `AURM_ADDR_RESULT || a == `AURM_ADDR_QCTL ||
             a == `AURM_ADDR_QLIM || a == `AURM_ADDR_QDATA ||
             (a >= `AURM_CHAN_BASE && a <= `AURM_CHAN_LAST) ||
             (a >= `AURM_FILT_BASE && a <= `AURM_GAIN_LAST))
      n = 2'd3;
    return n;
  endfunction

  // Keep writable bits only
  function automatic logic [23:0] mw(input logic [23:0] o,
                                      input logic [23:0] d,
                                      input logic [23:0] m);
    return (o & ~m) | (d & m);
  endfunction

  // Link side: byte framing
  assign sh_nxt   = {sh_r[6:0], sdi};
  assign byte_end = (bit_cnt_r == 3'd7);
  assign cur_len  = reg_len(addr_r);
  assign rd_addr  = sh_nxt[5:0];
  assign rd_len   = reg_len(rd_addr);
  assign sw_hit   = sdi && (ones_r == 6'(`AURM_SWRST_ONES - 1));
  assign sdo_oe   = ~cs_n;

  // Bit counter and shifter, cleared by frame end
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt_r <= 3'h0;
      sh_r      <= 8'h00;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_r      <= sh_nxt;
    end
  end

  // Run of ones for software reset
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      ones_r <= 6'h00;
    else if (!sdi || sw_hit)
      ones_r <= 6'h00;   // RL1
    else
      ones_r <= ones_r + 6'h01;
  end

  // Transaction phase
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      phase_r    <= aurm_pkg::ls_cmd;
      byte_cnt_r <= 2'd0;
      addr_r     <= 6'h00;
    end
    else if (byte_end)
    begin
      case (phase_r)
        aurm_pkg::ls_cmd:
        begin
          byte_cnt_r <= 2'd0;
          addr_r     <= sh_nxt[5:0];
          // Write-enable bit set: not a command, ignore frame
          if (sh_nxt[`AURM_CMD_WEN_BIT])
            phase_r <= aurm_pkg::ls_skip;
          else if (sh_nxt[`AURM_CMD_RD_BIT])
            phase_r <= aurm_pkg::ls_rd;
          else
            phase_r <= aurm_pkg::ls_wr;
        end
        aurm_pkg::ls_wr, aurm_pkg::ls_rd:
        begin
          byte_cnt_r <= byte_cnt_r + 2'd1;
          // Register-sized transfer, then next command
          if (byte_cnt_r == cur_len - 2'd1)
            phase_r <= aurm_pkg::ls_cmd;   // RL13
        end
        default:
          phase_r <= phase_r;
      endcase
    end
  end

  // Write data gathered MSB first
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      acc_r <= 24'h000000;
    else if (byte_end && phase_r == aurm_pkg::ls_cmd)
      acc_r <= 24'h000000;
    else if (byte_end && phase_r == aurm_pkg::ls_wr)
      acc_r <= {acc_r[15:0], sh_nxt};   // RL13
  end

  // Read data loaded MSB-aligned, shifted per bit
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      rd_sh_r <= 24'h000000;
    else if (byte_end && phase_r == aurm_pkg::ls_cmd)
    begin
      case (rd_len)
        2'd1:    rd_sh_r <= {rd_word[7:0], 16'h0000};   // RL13
        2'd2:    rd_sh_r <= {rd_word[15:0], 8'h00};
        default: rd_sh_r <= rd_word;
      endcase
    end
    else if (phase_r == aurm_pkg::ls_rd)
      rd_sh_r <= {rd_sh_r[22:0], 1'b0};
  end

  // Output bit changes on the falling edge
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      sdo <= 1'b0;
    else
      sdo <= (phase_r == aurm_pkg::ls_rd) ? rd_sh_r[23] : 1'b0;
  end

  // Commit and reset events, held until the next one
  always_ff @(posedge sclk or posedge srst)
  begin
    if (srst)
    begin
      wr_tgl_r  <= 1'b0;
      rst_tgl_r <= 1'b0;
      wa_r      <= 6'h00;
      wd_r      <= 24'h000000;
    end
    else if (!cs_n)
    begin
      if (byte_end && phase_r == aurm_pkg::ls_wr &&
          byte_cnt_r == cur_len - 2'd1)
      begin
        wa_r     <= addr_r;
        wd_r     <= {acc_r[15:0], sh_nxt};
        wr_tgl_r <= ~wr_tgl_r;
      end
      if (sw_hit)
        rst_tgl_r <= ~rst_tgl_r;   // RL1
    end
  end

  // Crossings into the master clock
  aurm_sync3 #(.RST_VAL(1'b1)) u_cs_sync (
    .clk  (mclk),
    .srst (srst),
    .d    (cs_n),
    .q    (cs_lvl),
    .chg  (cs_chg)
  );
  aurm_sync3 #(.RST_VAL(1'b0)) u_wr_sync (
    .clk  (mclk),
    .srst (srst),
    .d    (wr_tgl_r),
    .q    (),
    .chg  (wr_p)
  );
  aurm_sync3 #(.RST_VAL(1'b0)) u_rst_sync (
    .clk  (mclk),
    .srst (srst),
    .d    (rst_tgl_r),
    .q    (),
    .chg  (swr_p)
  );

  assign init        = srst | swr_p;
  assign frame_start = cs_chg & cs_lvl;
  assign wr_ok       = wr_p & ready_r & ~bad_r;
  assign dev_ready   = ready_r;
  assign conv_ctl    = ctl_r;

  // Initialisation delay after any reset
  always_ff @(posedge mclk)
  begin
    if (init)
    begin
      dly_r   <= '0;
      ready_r <= 1'b0;
    end
    else if (!ready_r)
    begin
      if (dly_r == DW'(DLY_CYC - 1))
        ready_r <= 1'b1;
      dly_r <= dly_r + DW'(1);
    end
  end

  // Frame opened before ready is invalid throughout
  always_ff @(posedge mclk)
  begin
    if (init)
      bad_r <= 1'b0;
    else if (frame_start)
      bad_r <= ~ready_r;   // RL4
  end

  // Early-access error: set wins over write-one clear
  always_ff @(posedge mclk)
  begin
    if (init)
      ign_r <= 1'b0;
    else if (frame_start && !ready_r &&
             faulten_r[`AURM_FAULT_IGN_BIT])
      ign_r <= 1'b1;   // RL4
    else if (wr_ok && wa_r == `AURM_ADDR_FAULT &&
             wd_r[`AURM_FAULT_IGN_BIT])
      ign_r <= 1'b0;   // RL5
  end

  // Master clock tally, enabled by its enable bit
  always_ff @(posedge mclk)
  begin
    if (init)
      tally_r <= 8'h00;
    else if (faulten_r[`AURM_EN_TALLY_BIT])
      tally_r <= tally_r + 8'h01;
  end

  // Single registers, writable bits only
  always_ff @(posedge mclk)
  begin
    if (init)
    begin
      ctl_r     <= `AURM_RST_CTL;
      io_r      <= `AURM_RST_IO;
      vbias_r   <= `AURM_RST_VBIAS;
      faulten_r <= `AURM_RST_FAULTEN;
      misc_r    <= `AURM_RST_MISC;
      qctl_r    <= `AURM_RST_QCTL;
      qlim_r    <= `AURM_RST_QLIM;
    end
    else if (wr_ok)
    begin
      case (wa_r)
        `AURM_ADDR_CTL:
          ctl_r <= 16'(mw({8'h00, ctl_r}, wd_r,
                          {8'h00, `AURM_MASK_CTL}));   // RL7
        `AURM_ADDR_IO:
          io_r <= 16'(mw({8'h00, io_r}, wd_r,
                         {8'h00, `AURM_MASK_IO}));   // RL7
        `AURM_ADDR_VBIAS:
          vbias_r <= 16'(mw({8'h00, vbias_r}, wd_r,
                            {8'h00, `AURM_MASK_VBIAS}));   // RL7
        `AURM_ADDR_FAULTEN:
          faulten_r <= 16'(mw({8'h00, faulten_r}, wd_r,
                              {8'h00, `AURM_MASK_FAULTEN}));
        `AURM_ADDR_MISC:  misc_r <= wd_r[15:0];
        `AURM_ADDR_QCTL:  qctl_r <= wd_r;
        `AURM_ADDR_QLIM:  qlim_r <= wd_r;
        default:          misc_r <= misc_r;   // RL14
      endcase
    end
  end

  // Per-setup and per-channel register arrays
  always_ff @(posedge mclk)
  begin
    if (init)
    begin
      for (int i = 0; i < 16; i++)
        chan_r[i] <= (i == 0) ? `AURM_RST_CHAN0 : `AURM_RST_CHAN; // RL8
      for (int i = 0; i < 8; i++)
      begin
        cfg_r[i]  <= `AURM_RST_CFG;    // RL9
        filt_r[i] <= `AURM_RST_FILT;   // RL10
        offs_r[i] <= `AURM_RST_OFFS;   // RL11
        gain_r[i] <= gain_trim;        // RL12
      end
    end
    else if (wr_ok)
    begin
      if (wa_r >= `AURM_CHAN_BASE && wa_r <= `AURM_CHAN_LAST)
        chan_r[4'(wa_r - `AURM_CHAN_BASE)] <= wd_r;   // RL8
      else if (wa_r >= `AURM_CFG_BASE && wa_r <= `AURM_CFG_LAST)
        cfg_r[3'(wa_r - `AURM_CFG_BASE)] <= wd_r[15:0];   // RL9
      else if (wa_r >= `AURM_FILT_BASE && wa_r <= `AURM_FILT_LAST)
        filt_r[3'(wa_r - `AURM_FILT_BASE)] <= wd_r;   // RL10
      else if (wa_r >= `AURM_OFFS_BASE && wa_r <= `AURM_OFFS_LAST)
        offs_r[3'(wa_r - `AURM_OFFS_BASE)] <= wd_r;   // RL11
      else if (wa_r >= `AURM_GAIN_BASE && wa_r <= `AURM_GAIN_LAST)
        gain_r[3'(wa_r - `AURM_GAIN_BASE)] <= wd_r;   // RL12
    end
  end

  // Readback mux; values change on commits of earlier frames, on resets, on early frames (ign_r) and as tally_r counts
  always_comb
  begin
    rd_word = 24'h000000;   // RL14
    if (rd_addr >= `AURM_CHAN_BASE && rd_addr <= `AURM_CHAN_LAST)
      rd_word = chan_r[4'(rd_addr - `AURM_CHAN_BASE)];
    else if (rd_addr >= `AURM_CFG_BASE && rd_addr <= `AURM_CFG_LAST)
      rd_word = {8'h00, cfg_r[3'(rd_addr - `AURM_CFG_BASE)]};
    else if (rd_addr >= `AURM_FILT_BASE && rd_addr <= `AURM_FILT_LAST)
      rd_word = filt_r[3'(rd_addr - `AURM_FILT_BASE)];
    else if (rd_addr >= `AURM_OFFS_BASE && rd_addr <= `AURM_OFFS_LAST)
      rd_word = offs_r[3'(rd_addr - `AURM_OFFS_BASE)];
    else if (rd_addr >= `AURM_GAIN_BASE && rd_addr <= `AURM_GAIN_LAST)
      rd_word = gain_r[3'(rd_addr - `AURM_GAIN_BASE)];
    else
    begin
      case (rd_addr)
        `AURM_ADDR_STATUS:  rd_word = {16'h0000, `AURM_RST_STATUS};
        `AURM_ADDR_CTL:     rd_word = {8'h00, ctl_r};
        `AURM_ADDR_IO:      rd_word = {8'h00, io_r};
        `AURM_ADDR_VBIAS:   rd_word = {8'h00, vbias_r};
        `AURM_ADDR_PARTID:  rd_word = {16'h0000, PART_ID};
        `AURM_ADDR_FAULT:
          rd_word = 24'(ign_r) << `AURM_FAULT_IGN_BIT;
        `AURM_ADDR_FAULTEN: rd_word = {8'h00, faulten_r};
        `AURM_ADDR_TALLY:   rd_word = {16'h0000, tally_r};
        `AURM_ADDR_MISC:    rd_word = {8'h00, misc_r};
        `AURM_ADDR_QCTL:    rd_word = qctl_r;
        `AURM_ADDR_QSTATE:  rd_word = {16'h0000, `AURM_RST_QSTATE};
        `AURM_ADDR_QLIM:    rd_word = qlim_r;
        default:            rd_word = 24'h000000;
      endcase
    end
  end

  // Checks on the master clock
  a_soft_reset: assert property (@(posedge mclk) disable iff (srst) // RL1
    swr_p |=> !ready_r && ctl_r == `AURM_RST_CTL && ign_r == 1'b0)
    else $error("software reset did not restore registers");
  a_early_flag: assert property (@(posedge mclk) disable iff (srst) // RL4
    frame_start && !ready_r && faulten_r[`AURM_FAULT_IGN_BIT]
    |=> ign_r && bad_r)
    else $error("early frame did not raise error");
  a_early_drop: assert property (@(posedge mclk) disable iff (srst) // RL4
    wr_p && (bad_r || !ready_r) |=> $stable(ctl_r) && $stable(misc_r))
    else $error("early write changed a register");
  a_w1c_hold: assert property (@(posedge mclk) disable iff (srst) // RL5
    ign_r && !(wr_ok && wa_r == `AURM_ADDR_FAULT &&
               wd_r[`AURM_FAULT_IGN_BIT]) && !swr_p |=> ign_r)
    else $error("error flag cleared without write-one");
  a_ro_bits: assert property (@(posedge mclk) disable iff (srst) // RL7
    !swr_p |=> (ctl_r & ~`AURM_MASK_CTL) ==
               ($past(ctl_r) & ~`AURM_MASK_CTL) &&
               (io_r & ~`AURM_MASK_IO) == ($past(io_r) & ~`AURM_MASK_IO))
    else $error("read-only bits changed");
  a_chan_reset: assert property (@(posedge mclk) disable iff (srst) // RL8
    swr_p |=> chan_r[0] == `AURM_RST_CHAN0 && chan_r[15] == `AURM_RST_CHAN)
    else $error("channel reset value wrong");
  a_cfg_reset: assert property (@(posedge mclk) disable iff (srst) // RL9
    swr_p |=> cfg_r[0] == `AURM_RST_CFG && cfg_r[7] == `AURM_RST_CFG)
    else $error("setup reset value wrong");
  a_filt_reset: assert property (@(posedge mclk) disable iff (srst) // RL10
    swr_p |=> filt_r[0] == `AURM_RST_FILT && filt_r[7] == `AURM_RST_FILT)
    else $error("filter reset value wrong");
  a_offs_reset: assert property (@(posedge mclk) disable iff (srst) // RL11
    swr_p |=> offs_r[3] == `AURM_RST_OFFS && offs_r[7] == `AURM_RST_OFFS)
    else $error("offset reset value wrong");
  a_gain_trim: assert property (@(posedge mclk) disable iff (srst) // RL12
    swr_p |=> gain_r[0] == $past(gain_trim) && gain_r[7] == $past(gain_trim))
    else $error("gain not loaded from trim");
  a_unmapped_wr: assert property (@(posedge mclk) disable iff (srst) // RL14
    wr_ok && wa_r > `AURM_ADDR_LAST |=> $stable(misc_r) && $stable(qlim_r)
    && $stable(ctl_r) && $stable(chan_r[0]))
    else $error("unmapped write changed a register");
  // Link-side framing check
  a_read_len: assert property (@(posedge sclk) disable iff (cs_n) // RL13
    phase_r == aurm_pkg::ls_rd && byte_end && byte_cnt_r == cur_len - 2'd1
    |=> phase_r == aurm_pkg::ls_cmd)
    else $error("read length not register sized");
  c_soft_reset: cover property (@(posedge mclk) disable iff (srst) swr_p);
  c_early_err: cover property (@(posedge mclk) disable iff (srst)
    frame_start && !ready_r);
  c_write_ok: cover property (@(posedge mclk) disable iff (srst)
    wr_ok && wa_r == `AURM_CHAN_BASE);
endmodule
`default_nettype wire

/* File: hdl/aurm_sync3.sv */
// Three-stage synchroniser with agreed-change detection
`timescale 1ns/1ps
`default_nettype none
module aurm_sync3 #(
  parameter logic RST_VAL = 1'b0   // Level held during reset
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic d,
  output var  logic q,
  output logic      chg
);
  logic s1_r;  // First stage, read by s2_r only
  logic s2_r;  // Second stage
  logic s3_r;  // Third stage

  // Shift chain
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts once stages two and three agree
  assign chg = (s2_r == s3_r) && (s3_r != q);

  // Accepted level
  always_ff @(posedge clk)
  begin
    if (srst)
      q <= RST_VAL;
    else if (chg)
      q <= s3_r;
  end
endmodule
`default_nettype wire

/* File: test/aurm_host_model.sv */
// Host-side serial link model that frames transfers into the bank
`timescale 1ns/1ps
`default_nettype none
module aurm_host_model (
  output var  logic sclk,
  output var  logic cs_n,
  input  wire logic sdo,
  output var  logic sdi
);
  // Link idles: clock parked high, select off, data at pull-down level
  // Select rises first, after all processes wait, so link state clears
  initial
  begin
    cs_n <= 1'b1;
    sclk <= 1'b1;
    sdi  <= 1'b0;
  end

  // Send n bits MSB first, 12 ns clock, capture sdo at each rising edge
  task automatic shift(input logic [31:0] d, input int n,
                       output logic [31:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk = 1'b0;
      sdi  = d[i];
      #6;
      sclk = 1'b1;
      q    = {q[30:0], sdo};
      #6;
    end
  endtask

  // One framed transfer, then release and leave the select-high gap
  task automatic frame(input logic [31:0] d, input int n,
                       output logic [31:0] q);
    cs_n = 1'b0;
    #6;
    shift(d, n, q);
    cs_n = 1'b1;
    sdi  = 1'b0;
    #60;
  endtask

  // Frame holding a run of n ones, n from 32 to 64
  task automatic ones(input int n);
    logic [31:0] q;
    cs_n = 1'b0;
    #6;
    shift('1, 32, q);
    shift('1, n - 32, q);
    cs_n = 1'b1;
    sdi  = 1'b0;
    #60;
  endtask
endmodule
`default_nettype wire

/* File: test/aurm_regbank_bench.sv */
// Self-checking bench for the register bank and its serial link
`timescale 1ns/1ps
`default_nettype none
module aurm_regbank_bench;
  localparam logic [7:0]  PID = 8'h5a;     // Arbitrary identity value
  localparam logic [23:0] GT  = 24'h555555; // Trim for gain registers
  logic             mclk;       // Master clock
  logic             srst;       // Reset
  wire logic        sclk;       // Link clock
  wire logic        cs_n;       // Frame select
  wire logic        sdi;        // Data to bank
  wire logic        sdo;        // Data from bank
  wire logic        sdo_oe;     // Data output enable
  wire logic        dev_ready;  // Init done
  wire logic [15:0] conv_ctl;   // Control register level
  int               err_total;  // Mismatches
  int               n_compared; // Comparisons
  // Writes: address, bytes, value written, value read back
  logic [55:0] mtab [9] = '{
    {6'h01, 2'd2, 24'h00ffff, 24'h007f7f}, {6'h03, 2'd2, 24'h00ffff,
    24'h0007ee}, {6'h04, 2'd2, 24'h00ffff, 24'h00cc33}, {6'h07, 2'd2,
    24'h00ffff, 24'h001fff}, {6'h00, 2'd1, 24'h0000ff, 24'h000010},
    {6'h3d, 2'd3, 24'hffffff, 24'h000000}, {6'h19, 2'd2, 24'h00abcd,
    24'h00abcd}, {6'h18, 2'd3, 24'h123456, 24'h123456}, {6'h3e, 2'd1,
    24'h0000ff, 24'h000000}};
  logic [25:0] e;               // Expected {bytes, value}

  // Clock and reset
  initial
  begin
    mclk = 1'b0;
    srst = 1'b0;
  end
  always #5 mclk = ~mclk;

  aurm_regbank #(.DLY_CYC(8), .PART_ID(PID)) aurm_regbank_inst (
    .mclk      (mclk),
    .srst      (srst),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .sdi       (sdi),
    .sdo       (sdo),
    .sdo_oe    (sdo_oe),
    .gain_trim (GT),
    .dev_ready (dev_ready),
    .conv_ctl  (conv_ctl)
  );

  aurm_host_model aurm_host_model_inst (
    .sclk (sclk),
    .cs_n (cs_n),
    .sdo  (sdo),
    .sdi  (sdi)
  );

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  // Register write: command then nb data bytes
  task automatic wr(input logic [5:0] a, input logic [1:0] nb,
                    input logic [23:0] v);
    logic [31:0] q;
    aurm_host_model_inst.frame(({24'h0, 2'b00, a} << (8 * nb)) | v,
                               8 + 8 * nb, q);
  endtask

  // Register read of nb bytes, compared with exp
  task automatic rdchk(input logic [5:0] a, input logic [1:0] nb,
                       input logic [23:0] exp);
    logic [31:0] q;
    aurm_host_model_inst.frame({24'h0, 2'b01, a} << (8 * nb), 8 + 8 * nb, q);
    chk(q[23:0] & ~(24'hffffff << (8 * nb)), exp, "read");
  endtask

  // Bounded wait for a ready level
  task automatic wait_rdy(input logic v);
    int k;
    k = 0;
    while (dev_ready !== v && k < 300)
    begin
      @(posedge mclk);
      k++;
    end
    chk({23'h0, dev_ready}, {23'h0, v}, "ready");
    if (k == 300)
      tally_and_finish();
  endtask

  // Reset contents by address: {bytes, value}
  function automatic logic [25:0] rst_exp(input logic [5:0] a);
    case (a) inside
      6'h00: return {2'd1, 24'h000010};
      6'h01: return {2'd2, 24'h004000};
      6'h02, 6'h3d: return {2'd3, 24'h000000};
      6'h03, 6'h04, 6'h06, 6'h39: return {2'd2, 24'h000000};
      [6'h19:6'h20]: return {2'd2, 24'h000000};
      6'h05: return {2'd1, 16'h0, PID};
      6'h07: return {2'd2, 24'h000040};
      6'h08: return {2'd1, 24'h000000};
      6'h09: return {2'd3, 24'h800100};
      [6'h0a:6'h18]: return {2'd3, 24'h000100};
      [6'h21:6'h28]: return {2'd3, 24'h002030};
      [6'h29:6'h30]: return {2'd3, 24'h800000};
      [6'h31:6'h38]: return {2'd3, GT};
      6'h3a: return {2'd3, 24'h040200};
      6'h3b: return {2'd1, 24'h000001};
      6'h3c: return {2'd3, 24'hfff000};
      default: return {2'd1, 24'h000000};
    endcase
  endfunction

  // Main sequence
  initial
  begin
    err_total  = 0;
    n_compared = 0;
    // Reset edge after all processes wait, held 12 cycles
    srst <= 1'b1;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    // Write that starts before ready must be dropped and flagged
    wr(6'h01, 2'd2, 24'h001234);
    wait_rdy(1'b1);
    chk({8'h0, conv_ctl}, 24'h004000, "early write");
    rdchk(6'h06, 2'd2, 24'h000040);
    wr(6'h06, 2'd2, 24'h000000);
    rdchk(6'h06, 2'd2, 24'h000040);
    wr(6'h06, 2'd2, 24'h000040);
    rdchk(6'h06, 2'd2, 24'h000000);
    // Writable masks, read-only places, unmapped place
    for (int i = 0; i < 9; i++)
    begin
      wr(mtab[i][55:50], mtab[i][49:48], mtab[i][47:24]);
      rdchk(mtab[i][55:50], mtab[i][49:48], mtab[i][23:0]);
    end
    chk({8'h0, conv_ctl}, 24'h007f7f, "control level");
    // One short of the reset run changes nothing
    aurm_host_model_inst.ones(63);
    repeat (2) @(posedge mclk);
    chk({23'h0, dev_ready}, 24'h000001, "no reset");
    chk({8'h0, conv_ctl}, 24'h007f7f, "no reset");
    // Full run of ones resets every register
    aurm_host_model_inst.ones(64);
    wait_rdy(1'b0);
    wait_rdy(1'b1);
    chk({8'h0, conv_ctl}, 24'h004000, "after reset");
    for (int a = 0; a < 64; a++)
    begin
      e = rst_exp(a[5:0]);
      rdchk(a[5:0], e[25:24], e[23:0]);
    end
    // Output enable off while the link is idle
    chk({23'h0, sdo_oe}, 24'h000000, "idle enable");
    tally_and_finish();
  end
endmodule
`default_nettype wire
